// File: src/voice_cmd_cfg.svh
/*
 * Constants for the serial command front end: frame layout, control-bit
 * positions, storage geometry and timing at the 8 kHz sampling rate.
 * Assumes a 40 MHz system clock.
 */
`ifndef VOICE_CMD_CFG_SVH
`define VOICE_CMD_CFG_SVH
`define FRAME_BITS 16
`define ADDR_BITS 11
`define CTRL_LSB 11
`define BIT_CUE 11
`define BIT_KEEP 12
`define BIT_PWR 13
`define BIT_PLAY 14
`define BIT_RUN 15
`define ROW_COUNT 1200
`define ROW_CELLS 1600
`define CUE_SPEEDUP 1600
`define EOM_SLOTS 8
`define CLK_HZ 40000000
`define WAKE_US 25000
`define ROW_US 200000
`define ROW_LOW_US 25000
`define WAKE_CYC ((`WAKE_US * 40) / 1)
`define ROW_CYC (`ROW_US * 40)
`define ROW_LOW_CYC (`ROW_LOW_US * 40)
`endif

// File: src/voice_cmd_pkg.sv
/*
 * Types for the serial command front end.
 * Assumes the constants header is included by the design file.
 */
package voice_cmd_pkg;
	typedef enum logic [2:0] {
		ST_SLEEP = 3'b000,
		ST_WAKING = 3'b001,
		ST_IDLE = 3'b011,
		ST_PLAY = 3'b010,
		ST_CUE = 3'b110,
		ST_REC = 3'b111
	} op_state_t;
endpackage : voice_cmd_pkg

// File: src/voice_recorder_spi_command.sv
/*
 * Serial command front end of a voice record/playback device: SPI slave
 * shifting in 16-bit commands and out status, operation sequencer, row timer.
 * Assumes SPI pins are asynchronous to mclk (clock well below 1 MHz) and that
 * end-of-message marker detection is supplied by the storage array as a pulse.
 */
`timescale 1ns/1ps
`include "voice_cmd_cfg.svh"
module voice_recorder_spi_command #(
	parameter int WAKE_CYCLES = `WAKE_CYC,
	parameter int ROW_CYCLES = `ROW_CYC,
	parameter int ROW_LOW_CYCLES = `ROW_LOW_CYC
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	output logic miso_o,
	output logic miso_oe,
	output logic int_n_o,
	output logic int_n_oe,
	output logic row_tick_out_o,
	output logic row_tick_out_oe,
	input wire logic marker_hit
);
	localparam int CUE_ROW_CYCLES = ROW_CYCLES / `CUE_SPEEDUP;
	localparam int CUE_LOW_CYCLES = ROW_LOW_CYCLES / `CUE_SPEEDUP;
	localparam logic [10:0] LAST_ROW = 11'(`ROW_COUNT - 1);

	// two-flop synchronisers; stage one is read only by stage two
	logic [2:0] s1_q, s2_q, s3_q;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= 3'h2;
			s2_q <= 3'h2;
			s3_q <= 3'h2;
		end else begin
			s1_q <= {mosi, ss_n, sclk};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	wire sck_rise = s2_q[0] & ~s3_q[0];
	wire sck_fall = ~s2_q[0] & s3_q[0];
	wire sel_fall = ~s2_q[1] & s3_q[1];
	wire sel_rise = s2_q[1] & ~s3_q[1];
	wire selected = ~s2_q[1];

	// serial shift state
	logic [15:0] rx_q, rx_d, tx_q, tx_d;
	logic [4:0] cnt_q, cnt_d;
	logic miso_q, miso_d;
	logic ovf_q, ovf_d, eom_q, eom_d;
	logic [10:0] ptr_q, ptr_d;
	always_comb begin
		rx_d = rx_q;
		tx_d = tx_q;
		cnt_d = cnt_q;
		miso_d = miso_q;
		if (sel_fall) begin
			tx_d = {ptr_q, 3'h0, eom_q, ovf_q};
			miso_d = ovf_q;
			cnt_d = 5'h0;
		end else if (selected && sck_rise) begin
			rx_d = {s2_q[2], rx_q[15:1]};
			if (cnt_q != 5'h1f)
				cnt_d = cnt_q + 5'h1;
		end else if (selected && sck_fall) begin
			tx_d = {1'b0, tx_q[15:1]};
			miso_d = tx_q[1];
		end
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rx_q <= 16'h0;
			tx_q <= 16'h0;
			cnt_q <= 5'h0;
			miso_q <= 1'b0;
		end else begin
			rx_q <= rx_d;
			tx_q <= tx_d;
			cnt_q <= cnt_d;
			miso_q <= miso_d;
		end
	end
	assign miso_o = miso_q;
	assign miso_oe = selected;

	// command acceptance at end of a complete frame
	wire cmd_go = sel_rise && (cnt_q == 5'h10);
	wire c_cue = rx_q[`BIT_CUE];
	wire c_keep = rx_q[`BIT_KEEP];
	wire c_pwr = rx_q[`BIT_PWR];
	wire c_play = rx_q[`BIT_PLAY];
	wire c_run = rx_q[`BIT_RUN];
	wire [10:0] c_addr = rx_q[10:0];

	// operation sequencer, row timer and flags
	voice_cmd_pkg::op_state_t st_q, st_d;
	logic [31:0] tmr_q, tmr_d;
	logic [31:0] rt_q, rt_d;
	logic [10:0] row_q, row_d;
	logic int_q, int_d;
	logic keep_q, keep_d;
	logic tick_q, tick_d;
	logic [2:0] slot_q, slot_d;
	logic active;
	logic [31:0] row_len, low_len;
	logic row_end;
	always_comb begin
		st_d = st_q;
		tmr_d = tmr_q;
		rt_d = rt_q;
		row_d = row_q;
		ptr_d = ptr_q;
		ovf_d = ovf_q;
		eom_d = eom_q;
		int_d = int_q;
		keep_d = keep_q;
		slot_d = slot_q;
		active = (st_q == voice_cmd_pkg::ST_PLAY) || (st_q == voice_cmd_pkg::ST_CUE) ||
			(st_q == voice_cmd_pkg::ST_REC);
		row_len = (st_q == voice_cmd_pkg::ST_CUE) ? 32'(CUE_ROW_CYCLES) : 32'(ROW_CYCLES);
		low_len = (st_q == voice_cmd_pkg::ST_CUE) ? 32'(CUE_LOW_CYCLES) : 32'(ROW_LOW_CYCLES);
		row_end = active && (rt_q == row_len - 32'h1);
		tick_d = !(active && (rt_q >= row_len - low_len));
		if (sel_fall) begin
			int_d = 1'b0;
			ovf_d = 1'b0;
			eom_d = 1'b0;
		end
		if (active) begin
			rt_d = row_end ? 32'h0 : rt_q + 32'h1;
			if (rt_q == ((row_len >> 3) * (32'(slot_q) + 32'h1)) - 32'h1)
				slot_d = slot_q + 3'h1;
		end
		case (st_q)
			voice_cmd_pkg::ST_WAKING: begin
				if (tmr_q == 32'(WAKE_CYCLES) - 32'h1)
					st_d = voice_cmd_pkg::ST_IDLE;
				else
					tmr_d = tmr_q + 32'h1;
			end
			voice_cmd_pkg::ST_PLAY, voice_cmd_pkg::ST_CUE: begin
				if (marker_hit) begin
					// end flag only in playback modes; cue parks on the following row, or stays put on the last row
					eom_d = 1'b1;
					int_d = 1'b1;
					st_d = voice_cmd_pkg::ST_IDLE;
					if (st_q == voice_cmd_pkg::ST_CUE && row_q != LAST_ROW)
						row_d = row_q + 11'h1;
				end
			end
			default: ;
		endcase
		if (row_end && !marker_hit) begin
			slot_d = 3'h0;
			if (!keep_q) begin
				rt_d = 32'h0; // repeat the supplied row
			end else if (row_q == LAST_ROW) begin
				ovf_d = 1'b1;
				int_d = 1'b1;
				st_d = voice_cmd_pkg::ST_IDLE;
			end else begin
				row_d = row_q + 11'h1;
			end
		end
		if (cmd_go) begin
			keep_d = c_keep;
			if (!c_pwr) begin
				st_d = voice_cmd_pkg::ST_SLEEP;
			end else if (!c_run) begin
				if (st_q == voice_cmd_pkg::ST_SLEEP) begin
					st_d = voice_cmd_pkg::ST_WAKING;
					tmr_d = 32'h0;
				end else if (st_q != voice_cmd_pkg::ST_WAKING)
					st_d = voice_cmd_pkg::ST_IDLE;
			end else if (st_q == voice_cmd_pkg::ST_IDLE ||
					(active && !c_keep)) begin
				// new operation; cueing accepted only when playback is being started
				if (!c_keep)
					row_d = c_addr;
				rt_d = 32'h0;
				slot_d = 3'h0;
				if (!c_play)
					st_d = voice_cmd_pkg::ST_REC;
				else if (c_cue)
					st_d = voice_cmd_pkg::ST_CUE;
				else
					st_d = voice_cmd_pkg::ST_PLAY;
			end
		end
		// events win over the clear at a frame start
		if (sel_fall && !int_q && int_d)
			int_d = 1'b1;
		ptr_d = row_d;
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= voice_cmd_pkg::ST_SLEEP;
			tmr_q <= 32'h0;
			rt_q <= 32'h0;
			row_q <= 11'h0;
			ptr_q <= 11'h0;
			ovf_q <= 1'b0;
			eom_q <= 1'b0;
			int_q <= 1'b0;
			keep_q <= 1'b0;
			tick_q <= 1'b1;
			slot_q <= 3'h0;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			rt_q <= rt_d;
			row_q <= row_d;
			ptr_q <= ptr_d;
			ovf_q <= ovf_d;
			eom_q <= eom_d;
			int_q <= int_d;
			keep_q <= keep_d;
			tick_q <= tick_d;
			slot_q <= slot_d;
		end
	end
	// open drain: only ever drive low
	assign int_n_o = 1'b0;
	assign int_n_oe = int_q;
	assign row_tick_out_o = 1'b0;
	assign row_tick_out_oe = ~tick_q;

	chk_short_frame: assert property (@(posedge mclk) disable iff (!reset_n)
		(sel_rise && cnt_q != 5'h10) |=> (st_q == $past(st_q)))
		else $error("short frame changed state");
	chk_int_clear: assert property (@(posedge mclk) disable iff (!reset_n)
		(sel_fall && !marker_hit && !row_end) |=> !int_q)
		else $error("interrupt not cleared at frame start");
	chk_int_set: assert property (@(posedge mclk) disable iff (!reset_n)
		((st_q == voice_cmd_pkg::ST_PLAY || st_q == voice_cmd_pkg::ST_CUE) && marker_hit) |=> int_q && eom_q)
		else $error("end marker did not raise interrupt");
	chk_eom_play: assert property (@(posedge mclk) disable iff (!reset_n)
		$rose(eom_q) |-> ($past(st_q) == voice_cmd_pkg::ST_PLAY || $past(st_q) == voice_cmd_pkg::ST_CUE))
		else $error("end flag outside playback");
	chk_miso_float: assert property (@(posedge mclk) disable iff (!reset_n)
		miso_oe == !$past(ss_n, 2))
		else $error("output driven while unselected");
	chk_sleep_cmd: assert property (@(posedge mclk) disable iff (!reset_n)
		(cmd_go && !c_pwr) |=> st_q == voice_cmd_pkg::ST_SLEEP)
		else $error("power down not taken");
	chk_wake_wait: assert property (@(posedge mclk) disable iff (!reset_n)
		(st_q == voice_cmd_pkg::ST_WAKING && tmr_q < 32'(WAKE_CYCLES) - 32'h1 && !cmd_go) |=>
		st_q == voice_cmd_pkg::ST_WAKING)
		else $error("ready before wake delay");
	chk_start_row: assert property (@(posedge mclk) disable iff (!reset_n)
		(cmd_go && c_pwr && c_run && !c_keep && st_q == voice_cmd_pkg::ST_IDLE) |=> row_q == $past(c_addr))
		else $error("start row not loaded");
	chk_status_load: assert property (@(posedge mclk) disable iff (!reset_n)
		sel_fall |=> tx_q[15:5] == $past(ptr_q) && tx_q[0] == $past(ovf_q))
		else $error("status word wrong");
endmodule : voice_recorder_spi_command

// File: testbench/spi_master_model.sv
/*
 * Model of the microcontroller that masters the serial link: frames sent
 * lsb first, status captured just before each rising serial clock.
 * Assumes mclk paces it and the device samples the link clock with mclk.
 */
`timescale 1ns/1ps
module spi_master_model (
	input wire logic mclk,
	output logic sclk,
	output logic ss_n,
	output logic mosi,
	input wire logic miso
);
	// link clock stands low and select high between frames
	initial begin
		sclk = 1'b0;
		ss_n = 1'b1;
		mosi = 1'b0;
	end

	// one frame of n bits; n below 16 gives a short frame on purpose
	task automatic xfer(input logic [15:0] cmd, input int n, output logic [15:0] rsp);
		rsp = 16'h0000;
		@(posedge mclk) ss_n <= 1'b0;
		mosi <= cmd[0];
		for (int i = 0; i < n; i++) begin
			repeat (3) @(posedge mclk);
			@(negedge mclk) rsp[i] = miso;
			@(posedge mclk) sclk <= 1'b1;
			repeat (4) @(posedge mclk);
			sclk <= 1'b0;
			mosi <= cmd[(i + 1) % 16];
		end
		repeat (4) @(posedge mclk);
		ss_n <= 1'b1;
		// hold time over, so the data line no longer shows the last bit
		mosi <= ~mosi;
		repeat (48) @(posedge mclk);
	endtask : xfer
endmodule : spi_master_model

// File: testbench/voice_recorder_spi_command_test.sv
/*
 * Self-checking bench of the serial command front end against an integer
 * model of pointer and flags. Assumes shortened wake and row timing.
 */
`timescale 1ns/1ps
module voice_recorder_spi_command_test;
	logic mclk, reset_n, marker_hit, sclk, ss_n, mosi, miso;
	logic miso_o, miso_oe, int_n_o, int_n_oe, row_tick_out_o, row_tick_out_oe;
	logic [15:0] rsp;
	int num_errors = 0;
	int checks = 0;
	int ptr = 0;
	int end_of_message_flag = 0;
	int ovf = 0;
	int run = 0;
	int low_len = 0;

	voice_recorder_spi_command #(.WAKE_CYCLES(64), .ROW_CYCLES(3200), .ROW_LOW_CYCLES(400))
	voice_recorder_spi_command_i (.mclk(mclk), .reset_n(reset_n), .sclk(sclk), .ss_n(ss_n),
		.mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
		.row_tick_out_o(row_tick_out_o), .row_tick_out_oe(row_tick_out_oe), .marker_hit(marker_hit));
	spi_master_model spi_master_model_i (.mclk(mclk), .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso));
	// released line shows no stale level
	assign miso = miso_oe ? miso_o : ~miso_o;

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// length of each low phase of the row tick
	always @(negedge mclk) begin
		if (row_tick_out_oe === 1'b1) run++;
		else begin
			if (run > 0) low_len = run;
			run = 0;
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [15:0] stat();
		return {11'(ptr), 3'h0, 1'(end_of_message_flag), 1'(ovf)};
	endfunction : stat

	// frame; flags clear as this frame begins, once the status word is loaded
	task automatic frame(input logic [15:0] cmd, input int n);
		spi_master_model_i.xfer(cmd, n, rsp);
	endtask : frame

	task automatic wait_int(input int n);
		for (int k = 0; k < n && int_n_oe !== 1'b1; k++) @(negedge mclk);
	endtask : wait_int

	task automatic end_sim();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_sim

	initial begin
		#1ms;
		num_errors++;
		end_sim();
	end

	initial begin
		reset_n = 1'b0;
		marker_hit = 1'b0;
		void'($urandom(72));
		repeat (3) @(posedge mclk);
		check(16'({int_n_oe, miso_oe, row_tick_out_oe, int_n_o, row_tick_out_o}), 16'h0000);
		reset_n <= 1'b1;
		// play while asleep is refused
		frame(16'he005, 16);
		check(rsp, stat());
		check(16'(miso_oe), 16'h0000);
		frame(16'h2000, 16);
		repeat (80) @(posedge mclk);
		ptr = 1197;
		frame(16'he000 | 16'(ptr), 16);
		repeat (100) @(posedge mclk);
		marker_hit <= 1'b1;
		@(posedge mclk) marker_hit <= 1'b0;
		repeat (8) @(negedge mclk);
		check(16'(int_n_oe), 16'h0001);
		end_of_message_flag = 1;
		frame(16'h3000, 16);
		check(rsp, stat());
		check(16'(int_n_oe), 16'h0000);
		end_of_message_flag = 0;
		// keep-address play runs across rows to the end of memory
		frame(16'hf000, 16);
		check(rsp, stat());
		wait_int(12000);
		check(16'(int_n_oe), 16'h0001);
		check(16'(low_len), 16'd400);
		frame(16'h3000, 16);
		check(16'(rsp[1:0]), 16'h0001);
		// short frame of halt and sleep is dropped, so recording works
		frame(16'h1000, 8);
		ptr = $urandom_range(1100, 0);
		frame(16'ha000 | 16'(ptr), 16);
		repeat (200) @(posedge mclk);
		frame(16'h3000, 16);
		check(rsp, stat());
		repeat (3300) @(posedge mclk);
		frame(16'h3000, 16);
		check(rsp, stat());
		check(16'(int_n_oe), 16'h0000);
		// a cue row lasts two cycles, too short to set keep-address in time, so cue from the current row
		ptr = 1190;
		frame(16'he000 | 16'h04a6, 16);
		frame(16'h3000, 16);
		frame(16'hf800, 16);
		check(rsp, stat());
		wait_int(100);
		check(16'(int_n_oe), 16'h0001);
		frame(16'h1000, 16);
		check(16'(rsp[1:0]), 16'h0001);
		frame(16'he005, 16);
		frame(16'h1000, 16);
		check(16'(rsp[15:5] == 11'd5), 16'h0000);
		end_sim();
	end
endmodule : voice_recorder_spi_command_test
